// >>> verilog/psram_config_access.sv
// PSRAM configuration register access and non-blocking read control
// Contract
// - Cancel aborts active read on channel 0/1
// - Accept config read for chip select 0-3 only while host_bus_sixteen_mode is set
// - Hold read enable; value valid after drop
// - Write config value via config enable
// - Low window accesses may corrupt data
// - High window accesses need no guard
// - Read fills FIFO, pauses when full
`timescale 1ns/1ns
`default_nettype none
module psram_config_access (
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    // Mode and configuration requests
    input  wire logic                                 host_bus_sixteen_mode,
    input  wire logic                                 cfg_read_req,
    input  wire logic                                 cfg_write_req,
    input  wire logic [psram_cfg_pkg::CS_W-1:0]       chip_select_index,
    input  wire logic [psram_cfg_pkg::DATA_W-1:0]     cfg_wdata,
    output logic                                      cfg_read_en,
    output logic                                      cfg_write_en,
    output logic [psram_cfg_pkg::DATA_W-1:0]          cfg_value,
    output logic                                      cfg_refused,
    // Memory side
    output logic [3:0]                                mem_cs,
    output logic [psram_cfg_pkg::DATA_W-1:0]          mem_dout,
    output logic                                      mem_doe,
    input  wire logic [psram_cfg_pkg::DATA_W-1:0]     mem_din,
    // Non-blocking read channels
    input  wire logic                                 nb_start,
    input  wire logic                                 nb_cancel,
    input  wire logic                                 read_channel_index,
    input  wire logic [psram_cfg_pkg::CNT_W-1:0]      nb_count,
    input  wire logic                                 fifo_full,
    input  wire logic                                 item_done,
    output logic [1:0]                                nb_busy,
    output logic [1:0]                                nb_fetch,
    // Window access guard
    input  wire logic                                 acc_req,
    input  wire logic [psram_cfg_pkg::ADDR_W-1:0]     acc_addr,
    output logic                                      acc_go
);
    import psram_cfg_pkg::*;

    cfg_state_e        state_reg, state_next;
    logic [3:0]        cnt_reg, cnt_next;
    logic [1:0]        cs_reg, cs_next;
    logic [DATA_W-1:0] val_reg, val_next;
    logic [DATA_W-1:0] wd_reg, wd_next;
    logic              ref_reg, ref_next;
    logic [2:0]        guard_reg, guard_next;
    logic              go_reg, go_next;
    logic              rd_en_reg, rd_en_next;
    logic              wr_en_reg, wr_en_next;
    logic [3:0]        cs_oh_reg, cs_oh_next;
    logic [1:0]        busy_w, fetch_w;
    logic [1:0]        busy_reg, fetch_reg;
    logic              mode_s1_reg, mode_s2_reg;
    logic [DATA_W-1:0] din_s1_reg, din_s2_reg;

    // Configuration sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cs_next    = cs_reg;
        val_next   = val_reg;
        wd_next    = wd_reg;
        ref_next   = 1'b0;
        case (state_reg)
            CFG_IDLE: begin
                if ((cfg_read_req || cfg_write_req) && !mode_s2_reg) begin
                    ref_next = 1'b1;
                end else if (cfg_read_req) begin
                    state_next = CFG_READ;
                    cs_next    = chip_select_index;
                    cnt_next   = CFG_CYCLES + SYNC_LAG_CYCLES;
                end else if (cfg_write_req) begin
                    state_next = CFG_WRITE;
                    cs_next    = chip_select_index;
                    wd_next    = cfg_wdata;
                    cnt_next   = CFG_CYCLES;
                end
            end
            CFG_READ: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    val_next   = din_s2_reg;
                    state_next = CFG_IDLE;
                end
            end
            CFG_WRITE: begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = CFG_IDLE;
                end
            end
            default: state_next = CFG_IDLE;
        endcase
        // Strobes registered from the next state
        rd_en_next = state_next == CFG_READ;
        wr_en_next = state_next == CFG_WRITE;
        cs_oh_next = (state_next == CFG_IDLE) ? 4'h0 : 4'(4'h1 << cs_next);
    end

    // Low window guard: two extra cycles before the access proceeds
    always_comb begin
        guard_next = 3'h0;
        go_next    = 1'b0;
        if (acc_req && in_low_window(acc_addr)) begin
            guard_next = (guard_reg == GUARD_CYCLES) ? GUARD_CYCLES : guard_reg + 3'h1;
            go_next    = guard_reg == GUARD_CYCLES;
        end else if (acc_req) begin
            go_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg   <= CFG_IDLE;
            cnt_reg     <= 4'h0;
            cs_reg      <= 2'h0;
            val_reg     <= CFG_RESET;
            wd_reg      <= CFG_RESET;
            ref_reg     <= 1'b0;
            guard_reg   <= 3'h0;
            go_reg      <= 1'b0;
            rd_en_reg   <= 1'b0;
            wr_en_reg   <= 1'b0;
            cs_oh_reg   <= 4'h0;
            busy_reg    <= 2'h0;
            fetch_reg   <= 2'h0;
            mode_s1_reg <= 1'b0;
            mode_s2_reg <= 1'b0;
            din_s1_reg  <= '0;
            din_s2_reg  <= '0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            cs_reg      <= cs_next;
            val_reg     <= val_next;
            wd_reg      <= wd_next;
            ref_reg     <= ref_next;
            guard_reg   <= guard_next;
            go_reg      <= go_next;
            rd_en_reg   <= rd_en_next;
            wr_en_reg   <= wr_en_next;
            cs_oh_reg   <= cs_oh_next;
            busy_reg    <= busy_w;
            fetch_reg   <= fetch_w;
            mode_s1_reg <= host_bus_sixteen_mode;
            mode_s2_reg <= mode_s1_reg;
            din_s1_reg  <= mem_din;
            din_s2_reg  <= din_s1_reg;
        end
    end

    // Two read channels
    for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
        nb_read_channel u_chan (
            .clk       (clk),
            .nrst      (nrst),
            .start     (nb_start && (read_channel_index == 1'(c))),
            .count     (nb_count),
            .cancel    (nb_cancel && (read_channel_index == 1'(c))),
            .fifo_full (fifo_full),
            .item_done (item_done && (read_channel_index == 1'(c))),
            .busy      (busy_w[c]),
            .fetch     (fetch_w[c]),
            .remain    ()
        );
    end

    assign cfg_read_en  = rd_en_reg;
    assign cfg_write_en = wr_en_reg;
    assign cfg_value    = val_reg;
    assign cfg_refused  = ref_reg;
    assign mem_cs       = cs_oh_reg;
    assign mem_dout     = wd_reg;
    assign mem_doe      = wr_en_reg;
    assign nb_busy      = busy_reg;
    assign nb_fetch     = fetch_reg;
    assign acc_go       = go_reg;

    a_read_en_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cfg_read_en) |-> cfg_read_en [*3] ##1 !cfg_read_en)
        else $error("read enable length wrong");
    a_write_en_len: assert property (@(posedge clk) disable iff (!nrst)
        $rose(cfg_write_en) |-> cfg_write_en [*2] ##1 !cfg_write_en)
        else $error("write enable length wrong");
    a_value_after_drop: assert property (@(posedge clk) disable iff (!nrst)
        cfg_read_en |=> $stable(cfg_value) || $fell(cfg_read_en))
        else $error("config value changed while enable high");
    a_mode_refuse: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == CFG_IDLE && cfg_read_req && !mode_s2_reg) |=> cfg_refused && !cfg_read_en)
        else $error("request not refused outside host mode");
    a_write_start: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == CFG_IDLE && !cfg_read_req && cfg_write_req && mode_s2_reg) |=> cfg_write_en && mem_doe)
        else $error("write enable not raised");
    a_cs_select: assert property (@(posedge clk) disable iff (!nrst)
        (state_reg == CFG_IDLE && (cfg_read_req || cfg_write_req) && mode_s2_reg)
        |=> mem_cs == 4'(4'h1 << $past(chip_select_index)))
        else $error("chip select does not follow request");
    a_cancel_idle: assert property (@(posedge clk) disable iff (!nrst)
        nb_cancel |=> ##1 !nb_busy[$past(read_channel_index, 2)] && !nb_fetch[$past(read_channel_index, 2)])
        else $error("channel not cancelled");
    a_full_pause: assert property (@(posedge clk) disable iff (!nrst)
        fifo_full |=> nb_fetch == 2'h0)
        else $error("fetch while fifo full");
    a_guard_low: assert property (@(posedge clk) disable iff (!nrst)
        $rose(acc_req) && in_low_window(acc_addr) |=> !acc_go [*2])
        else $error("low window access not delayed");
    a_guard_grant: assert property (@(posedge clk) disable iff (!nrst)
        (acc_req && in_low_window(acc_addr)) [*3] |=> acc_go)
        else $error("low window access never granted");
    a_high_free: assert property (@(posedge clk) disable iff (!nrst)
        acc_req && !in_low_window(acc_addr) |=> acc_go)
        else $error("high window access delayed");
endmodule
`default_nettype wire

// >>> verilog/psram_cfg_pkg.sv
// Constants for the PSRAM configuration access block
package psram_cfg_pkg;
    localparam int CS_W            = 2;
    localparam int CHAN_N          = 2;
    localparam int DATA_W          = 16;
    localparam int ADDR_W          = 32;
    localparam int CNT_W           = 12;
    localparam logic [31:0] LOW_WINDOW_BASE  = 32'h1000_0000;
    localparam logic [31:0] HIGH_WINDOW_BASE = 32'h6000_0000;
    localparam logic [3:0]  WINDOW_MASK_BITS = 4'hf;
    localparam logic [2:0]  GUARD_CYCLES     = 3'h2;
    localparam logic [DATA_W-1:0] CFG_RESET  = 16'h0000;
    localparam int CFG_CYCLES_NS   = 200;
    localparam int CLK_PERIOD_NS   = 100;
    localparam logic [3:0] CFG_CYCLES =
        4'((CFG_CYCLES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Read data needs one more cycle through the pin synchroniser
    localparam logic [3:0] SYNC_LAG_CYCLES = 4'h1;

    typedef enum logic [1:0] {
        CFG_IDLE  = 2'b00,
        CFG_READ  = 2'b01,
        CFG_WRITE = 2'b10
    } cfg_state_e;

    function automatic logic in_low_window(input logic [31:0] a);
        in_low_window = (a[31:28] & WINDOW_MASK_BITS) == LOW_WINDOW_BASE[31:28];
    endfunction
endpackage

// >>> verilog/nb_read_channel.sv
// One non-blocking read channel with count and cancel
`timescale 1ns/1ns
`default_nettype none
module nb_read_channel (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // Control
    input  wire logic                           start,
    input  wire logic [psram_cfg_pkg::CNT_W-1:0] count,
    input  wire logic                           cancel,
    input  wire logic                           fifo_full,
    input  wire logic                           item_done,
    // Status
    output logic                                busy,
    output logic                                fetch,
    output logic [psram_cfg_pkg::CNT_W-1:0]      remain
);
    import psram_cfg_pkg::*;

    logic             busy_reg;
    logic             busy_next;
    logic [CNT_W-1:0] remain_reg;
    logic [CNT_W-1:0] remain_next;

    always_comb begin
        busy_next   = busy_reg;
        remain_next = remain_reg;
        if (cancel) begin
            busy_next   = 1'b0;
            remain_next = '0;
        end else if (!busy_reg && start && count != '0) begin
            busy_next   = 1'b1;
            remain_next = count;
        end else if (busy_reg && item_done) begin
            remain_next = remain_reg - 12'h001;
            busy_next   = remain_reg != 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_reg   <= 1'b0;
            remain_reg <= '0;
        end else begin
            busy_reg   <= busy_next;
            remain_reg <= remain_next;
        end
    end

    assign busy   = busy_reg;
    assign remain = remain_reg;
    assign fetch  = busy_reg && !fifo_full && !cancel;
endmodule
`default_nettype wire

// >>> tb/psram_model.sv
// Behavioural PSRAM with four configuration registers
`timescale 1ns/1ns
`default_nettype none
module psram_model (
    // Clock
    input  wire logic        clk,
    // Memory side
    input  wire logic [3:0]  mem_cs,
    input  wire logic [15:0] mem_dout,
    input  wire logic        mem_doe,
    input  wire logic        cfg_write_en,
    output logic      [15:0] mem_din
);
    logic [15:0] cfg [4];
    logic [15:0] last;
    logic [1:0]  idx;
    initial begin
        last = 16'h0000;
        for (int i = 0; i < 4; i++) cfg[i] = 16'h0000;
    end
    always_comb begin
        idx = 2'h0;
        for (int i = 0; i < 4; i++) if (mem_cs[i]) idx = 2'(i);
    end
    // Released bus shows inverse of last value
    assign mem_din = (mem_cs != 4'h0) ? cfg[idx] : ~last;
    always @(posedge clk) begin
        last <= mem_din;
        if (cfg_write_en && mem_doe && mem_cs != 4'h0) cfg[idx] <= mem_dout;
    end
endmodule
`default_nettype wire

// >>> tb/psram_config_access_test.sv
// Self-checking bench for the PSRAM configuration access block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module psram_config_access_test;
    import psram_cfg_pkg::*;
    logic clk = 0, nrst = 0, mode = 0, rd_req = 0, wr_req = 0, nb_start = 0, nb_cancel = 0;
    logic ch = 0, fifo_full = 0, item_done = 0, acc_req = 0;
    logic [1:0] cs = 0, nb_busy, nb_fetch;
    logic [15:0] wdata = 0, cfg_value, mem_dout, mem_din, exp_cfg [4];
    logic [11:0] nb_count = 0;
    logic [31:0] acc_addr = 0;
    logic [3:0] mem_cs;
    logic cfg_read_en, cfg_write_en, cfg_refused, mem_doe, acc_go;
    int miscompares = 0, cmp_count = 0, n, nl, nh;
    psram_config_access dut (.clk(clk), .nrst(nrst), .host_bus_sixteen_mode(mode), .cfg_read_req(rd_req),
        .cfg_write_req(wr_req), .chip_select_index(cs), .cfg_wdata(wdata), .cfg_read_en(cfg_read_en),
        .cfg_write_en(cfg_write_en), .cfg_value(cfg_value), .cfg_refused(cfg_refused), .mem_cs(mem_cs),
        .mem_dout(mem_dout), .mem_doe(mem_doe), .mem_din(mem_din), .nb_start(nb_start), .nb_cancel(nb_cancel),
        .read_channel_index(ch), .nb_count(nb_count), .fifo_full(fifo_full), .item_done(item_done),
        .nb_busy(nb_busy), .nb_fetch(nb_fetch), .acc_req(acc_req), .acc_addr(acc_addr), .acc_go(acc_go));
    psram_model mem (.clk(clk), .mem_cs(mem_cs), .mem_dout(mem_dout), .mem_doe(mem_doe),
        .cfg_write_en(cfg_write_en), .mem_din(mem_din));
    initial forever #50 clk = ~clk;
    function automatic int guard_extra(input logic [31:0] a);
        return (a[31:28] == LOW_WINDOW_BASE[31:28]) ? int'(GUARD_CYCLES) : 0;
    endfunction
    function automatic int en_cycles(input logic rd);
        return rd ? int'(CFG_CYCLES + SYNC_LAG_CYCLES) : int'(CFG_CYCLES);
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_bit(input int sel, input logic val, output int k);
        logic s;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
            case (sel)
                0: s = cfg_read_en;
                1: s = cfg_write_en;
                2: s = nb_busy[0];
                3: s = nb_busy[1];
                4: s = cfg_refused;
                default: s = acc_go;
            endcase
        end while (s !== val && k < 60);
        if (s !== val) begin
            $display("[FAIL] wait %0d timed out", sel);
            miscompares++;
            give_verdict();
        end
    endtask
    task automatic cfg_op(input logic rd, input logic [1:0] c, input logic [15:0] d);
        @(negedge clk);
        rd_req = rd;
        wr_req = !rd;
        cs = c;
        wdata = d;
        wait_bit(rd ? 0 : 1, 1, n);
        `CHK("mem_cs", 4'h1 << c, mem_cs)
        @(negedge clk);
        rd_req = 0;
        wr_req = 0;
        wait_bit(rd ? 0 : 1, 0, n);
        `CHK("en_len", en_cycles(rd), n)
        if (rd) `CHK("cfg_value", exp_cfg[c], cfg_value)
        else exp_cfg[c] = d;
    endtask
    task automatic nb_run(input logic c, input logic [11:0] cnt);
        @(negedge clk);
        ch = c;
        nb_count = cnt;
        nb_start = 1;
        wait_bit(2 + c, 1, n);
        @(negedge clk);
        nb_start = 0;
    endtask
    task automatic guard(input logic [31:0] a, output int k);
        @(negedge clk);
        acc_addr = a;
        acc_req = 1;
        wait_bit(5, 1, k);
        @(negedge clk);
        acc_req = 0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        void'($urandom(5789));
        repeat (5) @(negedge clk);
        nrst = 1;
        repeat (3) @(negedge clk);
        rd_req = 1;
        wait_bit(4, 1, n);
        `CHK("refused", 1'b1, cfg_refused)
        @(negedge clk);
        rd_req = 0;
        mode = 1;
        repeat (3) @(negedge clk);
        $display("test refusal done");
        for (int i = 0; i < 4; i++) cfg_op(0, 2'(i), 16'($urandom));
        for (int i = 3; i >= 0; i--) cfg_op(1, 2'(i), 16'h0000);
        cfg_op(0, 2'h2, 16'hffff);
        cfg_op(1, 2'h2, 16'h0000);
        $display("test config done");
        @(negedge clk);
        fifo_full = 1;
        nb_run(0, 12'h002);
        repeat (3) @(negedge clk);
        `CHK("paused", 1'b0, nb_fetch[0])
        fifo_full = 0;
        repeat (2) @(negedge clk);
        `CHK("fetch", 1'b1, nb_fetch[0])
        repeat (2) begin
            item_done = 1;
            @(negedge clk);
            item_done = 0;
            @(negedge clk);
        end
        wait_bit(2, 0, n);
        `CHK("done", 1'b0, nb_busy[0])
        nb_run(1, 12'(1 + $urandom % 4095));
        `CHK("fetch1", 1'b1, nb_fetch[1])
        nb_cancel = 1;
        @(negedge clk);
        nb_cancel = 0;
        wait_bit(3, 0, n);
        `CHK("cancel", 2'b00, nb_busy)
        nb_run(1, 12'h001);
        `CHK("restart", 1'b1, nb_busy[1])
        item_done = 1;
        @(negedge clk);
        item_done = 0;
        wait_bit(3, 0, n);
        $display("test channels done");
        guard(HIGH_WINDOW_BASE | 32'($urandom % 65536), nh);
        guard(LOW_WINDOW_BASE | 32'($urandom % 65536), nl);
        `CHK("high_go", 1, nh)
        `CHK("extra", guard_extra(LOW_WINDOW_BASE), nl - nh)
        $display("test guard done");
        give_verdict();
    end
endmodule
`default_nettype wire
